// [hdl/hbs_regs.vh]
// constants of the hub boot stage sequencer
`ifndef HBS_REGS_VH
`define HBS_REGS_VH
// register written by the configuring SoC to end its session
`define HBS_SESSION_END_ADDR 8'hFF
// firmware-upgrade signature "2DFU" and where it lives in flash
`define HBS_SIG_WORD   32'h32444655
`define HBS_SIG_ADDR   24'h00FFFA
// external code starts here once the signature is accepted
`define HBS_CODE_START 16'h0000
// flash read commands, single and dual output
`define HBS_CMD_READ   8'h03
`define HBS_CMD_DREAD  8'h3B
// flash transfer shape in sck cycles
`define HBS_HDR_CLKS   7'h20
`define HBS_DUMMY_CLKS 7'h08
`define HBS_LAST_SGL   7'h3F
`define HBS_LAST_DUAL  7'h37
// config entry that carries strap overrides, and its fields
`define HBS_STRAP_IDX  3'h0
`define HBS_BC_LSB     0
`define HBS_BC_W       3
`define HBS_NONREM_LSB 3
`define HBS_NONREM_W   3
`endif

// [hdl/hbs_sync.v]
// three-stage synchroniser for pins, change taken when stages two and three agree
`timescale 1ns/1ps
module hbs_sync #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         clk,   // sampling clock
    input  wire         rst,   // synchronous reset
    input  wire [W-1:0] d,     // asynchronous pins
    output reg  [W-1:0] q      // filtered synchronous level
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);

    always @(posedge clk)
    begin
        if (rst)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q    <= INIT;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= (s2_r & agree) | (q & ~agree);
        end
    end
endmodule // hbs_sync

// [hdl/hbs_spi_sig.v]
// flash signature reader: single or dual read, spi mode 0 or 3
`timescale 1ns/1ps
`include "hbs_regs.vh"
module hbs_spi_sig #(
    parameter DIV = 2
) (
    input  wire clk,      // system clock
    input  wire rst,      // synchronous reset
    input  wire start,    // one-cycle pulse, starts a read
    input  wire dual,     // dual output read
    input  wire mode3,    // sck idles high
    input  wire io0_i,    // flash io0 sampled
    input  wire io1_i,    // flash io1 sampled
    output reg  sck,      // flash clock
    output reg  cs_n,     // flash select, active low
    output reg  io0_o,    // io0 drive value
    output reg  io0_oe,   // io0 drive enable
    output reg  done,     // one-cycle pulse at end of read
    output reg  sig_ok    // signature matched, held till next start
);
    reg        busy_r;
    reg [7:0]  div_r;
    reg [6:0]  cnt_r;
    reg [31:0] tx_r;
    reg [31:0] rx_r;
    wire [6:0] last_w  = dual ? `HBS_LAST_DUAL : `HBS_LAST_SGL;
    wire [6:0] dstart  = dual ? (`HBS_HDR_CLKS + `HBS_DUMMY_CLKS) : `HBS_HDR_CLKS;
    wire [6:0] cnt_nxt = cnt_r + 7'h01;
    wire [7:0] cmd_w   = dual ? `HBS_CMD_DREAD : `HBS_CMD_READ;

    always @(posedge clk)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            div_r  <= 8'h00;
            cnt_r  <= 7'h00;
            tx_r   <= 32'h0;
            rx_r   <= 32'h0;
            sck    <= 1'b0;
            cs_n   <= 1'b1;
            io0_o  <= 1'b0;
            io0_oe <= 1'b0;
            done   <= 1'b0;
            sig_ok <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (!busy_r)
            begin
                sck <= mode3;
                if (start)
                begin
                    busy_r <= 1'b1;
                    cs_n   <= 1'b0;
                    sck    <= 1'b0;
                    div_r  <= 8'h00;
                    cnt_r  <= 7'h00;
                    rx_r   <= 32'h0;
                    sig_ok <= 1'b0;
                    tx_r   <= {cmd_w, `HBS_SIG_ADDR};
                    io0_o  <= cmd_w[7];
                    io0_oe <= 1'b1;
                end
            end
            else if (div_r == DIV - 1)
            begin
                div_r <= 8'h00;
                if (!sck)
                begin
                    sck <= 1'b1;
                    if (cnt_r >= dstart)
                        rx_r <= dual ? {rx_r[29:0], io1_i, io0_i} : {rx_r[30:0], io1_i};
                end
                else if (cnt_r == last_w)
                begin
                    busy_r <= 1'b0;
                    cs_n   <= 1'b1;
                    sck    <= mode3;
                    done   <= 1'b1;
                    sig_ok <= (rx_r == `HBS_SIG_WORD);
                end
                else
                begin
                    sck   <= 1'b0;
                    cnt_r <= cnt_nxt;
                    tx_r  <= {tx_r[30:0], 1'b0};
                    io0_o <= tx_r[30];
                    if (cnt_nxt == `HBS_HDR_CLKS)
                        io0_oe <= 1'b0;
                end
            end
            else
                div_r <= div_r + 8'h01;
        end
    end
endmodule // hbs_spi_sig

// [hdl/hbs_boot_seq.v]
// hub boot and operating-stage sequencer
//
// How it works
// - reset pin low: standby, ports high impedance, pll stopped, only reset watched
// - entering standby aborts everything but the pin synchronisers and restores every other register default
// - reset pin high: hub mode, walking the boot stages in order
// - after reset release: spi init, pll runs, config defaults loaded
// - spi init reads flash for the 2DFU signature at 0xFFFA
// - good signature: external rom enabled, fetch starts at address 0x0000
// - bad or missing signature: stay on internal rom, go to config read
// - flash read works single or dual, spi mode 0 or 3
// - spi not strapped: skip flash, go to config read
// - config read loads rom defaults, then strap values override them
// - strap stage latches the slave option strap; slave option samples bus pins for pull-ups
// - pull-ups on both pins: soc config stage, else otp config stage
// - soc config stage waits without timeout for soc writes
// - otp stage merges default, soc and otp data into the hub
// - configured: idle, suspended while vbus is absent
// - vbus present: charger detection if charging enabled, else connect
// - connect stage drives usb connect while vbus high, leaves when low
// - normal mode holds full usb operation until mode changes
// - otp via usb only in normal mode, via smbus only in soc stage
// - upstream host may override battery charging at runtime
// - slave setup option strap with pull-ups on both bus pins puts the smbus interface into slave mode
`timescale 1ns/1ps
`include "hbs_regs.vh"
module hbs_boot_seq #(
    parameter            CFG_N       = 8,
    parameter [8*8-1:0]  CFG_DEFAULT = 64'h0,
    parameter            SPI_DIV     = 2
) (
    input  wire               ref_clk,                // 50 MHz clock
    input  wire               rst,                    // synchronous reset, high
    input  wire               chip_reset_n_pin,       // chip reset pin, low = standby
    input  wire               pll_lock_pin,           // pll locked
    input  wire               vbus_pin,               // upstream vbus function
    input  wire               mgmt_bus_data_pin,      // bus data level at boot
    input  wire               mgmt_bus_clock_pin,     // bus clock level at boot
    input  wire               strap_spi_en,           // spi mode strap
    input  wire               strap_spi_dual,         // dual flash strap
    input  wire               strap_spi_mode3,        // flash clock mode 3
    input  wire               slave_setup_option,     // config strap, slave option
    input  wire [2:0]         strap_bc_en,            // charging strap code
    input  wire [2:0]         strap_non_rem,          // non-removable strap code
    input  wire               spi_io0_i,              // flash io0 input
    input  wire               spi_io1_i,              // flash io1 input
    input  wire               cfg_wr_stb,             // soc register write pulse
    input  wire [7:0]         cfg_wr_addr,            // soc register address
    input  wire [7:0]         cfg_wr_data,            // soc register data
    input  wire [8*8-1:0]     otp_cfg_data,           // otp config bytes
    input  wire [7:0]         otp_cfg_vld,            // otp bytes present
    input  wire               chg_det_done,           // charger detection over
    input  wire               host_configured,        // upstream host took over
    input  wire               otp_smb_req,            // otp access from smbus
    input  wire               otp_usb_req,            // otp access from usb
    input  wire               bc_ovr_stb,             // host charging override pulse
    input  wire               bc_ovr_val,             // host charging override value
    output wire               spi_sck,                // flash clock
    output wire               spi_cs_n,               // flash select, low active
    output wire               spi_io0_o,              // flash io0 drive
    output wire               spi_io0_oe,             // flash io0 enable
    output reg  [10:0]        stage_r,                // current stage, one-hot
    output reg                ports_hiz_r,            // port interfaces high-z
    output reg                pll_run_r,              // pll enable
    output reg                ext_rom_en_r,           // external rom enabled
    output reg  [15:0]        ext_fetch_addr_r,       // external fetch start
    output reg                smb_slave_en_r,         // smbus slave mode on
    output reg                otp_smb_gnt_r,          // otp granted to smbus
    output reg                otp_usb_gnt_r,          // otp granted to usb
    output reg                hub_cfg_wr_r,           // merged entry write pulse
    output reg  [7:0]         hub_cfg_addr_r,         // merged entry index
    output reg  [7:0]         hub_cfg_data_r,         // merged entry value
    output reg                bc_en_r,                // battery charging enabled
    output reg                suspend_r,              // suspended in idle
    output reg                chg_det_start_r,        // start charger detect pulse
    output reg                usb_connect_r           // usb connect asserted
);
    // =========================================================
    // stages
    localparam [10:0] ST_STBY  = 11'h001;
    localparam [10:0] ST_SPI   = 11'h002;
    localparam [10:0] ST_EXT   = 11'h004;
    localparam [10:0] ST_CFGRD = 11'h008;
    localparam [10:0] ST_STRAP = 11'h010;
    localparam [10:0] ST_SOC   = 11'h020;
    localparam [10:0] ST_OTP   = 11'h040;
    localparam [10:0] ST_IDLE  = 11'h080;
    localparam [10:0] ST_CHG   = 11'h100;
    localparam [10:0] ST_CONN  = 11'h200;
    localparam [10:0] ST_NORM  = 11'h400;
    localparam        IW       = $clog2(CFG_N);

    // =========================================================
    // pin synchronisers
    wire       rstn_s;
    wire       lock_s;
    wire       vbus_s;
    wire       sda_s;
    wire       scl_s;
    wire       spi_en_s;
    wire       dual_s;
    wire       mode3_s;
    wire       slave_s;
    wire [2:0] bc_s;
    wire [2:0] nonrem_s;

    hbs_sync #(
        .W    (15),
        .INIT (15'h0000)
    ) u_sync (
        .clk (ref_clk),
        .rst (rst),
        .d   ({chip_reset_n_pin,
               pll_lock_pin,
               vbus_pin,
               mgmt_bus_data_pin,
               mgmt_bus_clock_pin,
               strap_spi_en,
               strap_spi_dual,
               strap_spi_mode3,
               slave_setup_option,
               strap_bc_en,
               strap_non_rem}),
        .q   ({rstn_s,
               lock_s,
               vbus_s,
               sda_s,
               scl_s,
               spi_en_s,
               dual_s,
               mode3_s,
               slave_s,
               bc_s,
               nonrem_s})
    );

    // =========================================================
    // flash signature reader
    reg  spi_start_r;
    reg  spi_busy_r;
    wire spi_done;
    wire spi_sig_ok;
    wire stby_w = rst | ~rstn_s;

    hbs_spi_sig #(
        .DIV (SPI_DIV)
    ) u_spi (
        .clk    (ref_clk),
        .rst    (stby_w),
        .start  (spi_start_r),
        .dual   (dual_s),
        .mode3  (mode3_s),
        .io0_i  (spi_io0_i),
        .io1_i  (spi_io1_i),
        .sck    (spi_sck),
        .cs_n   (spi_cs_n),
        .io0_o  (spi_io0_o),
        .io0_oe (spi_io0_oe),
        .done   (spi_done),
        .sig_ok (spi_sig_ok)
    );

    // =========================================================
    // config store: defaults, soc writes and their valid bits
    reg [7:0]    cfg_mem [0:CFG_N-1];
    reg [7:0]    soc_mem [0:CFG_N-1];
    reg [CFG_N-1:0] soc_vld_r;
    reg [IW-1:0] mi_r;
    reg          slave_lat_r;
    integer      i;

    // soc writes win: soc over otp over default
    function [7:0] merge_pick;
        input       soc_v;
        input [7:0] soc_d;
        input       otp_v;
        input [7:0] otp_d;
        input [7:0] def_d;
        begin
            merge_pick = soc_v ? soc_d : (otp_v ? otp_d : def_d);
        end
    endfunction

    wire [7:0] merged_w = merge_pick(soc_vld_r[mi_r], soc_mem[mi_r],
                                     otp_cfg_vld[mi_r], otp_cfg_data[mi_r*8 +: 8],
                                     cfg_mem[mi_r]);
    wire end_wr_w = cfg_wr_stb & (cfg_wr_addr == `HBS_SESSION_END_ADDR);

    // =========================================================
    // stage machine
    always @(posedge ref_clk)
    begin
        if (stby_w)
        begin
            stage_r          <= ST_STBY;
            ports_hiz_r      <= 1'b1;
            pll_run_r        <= 1'b0;
            ext_rom_en_r     <= 1'b0;
            ext_fetch_addr_r <= 16'h0000;
            smb_slave_en_r   <= 1'b0;
            otp_smb_gnt_r    <= 1'b0;
            otp_usb_gnt_r    <= 1'b0;
            hub_cfg_wr_r     <= 1'b0;
            hub_cfg_addr_r   <= 8'h00;
            hub_cfg_data_r   <= 8'h00;
            bc_en_r          <= 1'b0;
            suspend_r        <= 1'b0;
            chg_det_start_r  <= 1'b0;
            usb_connect_r    <= 1'b0;
            spi_start_r      <= 1'b0;
            spi_busy_r       <= 1'b0;
            soc_vld_r        <= {CFG_N{1'b0}};
            mi_r             <= {IW{1'b0}};
            slave_lat_r      <= 1'b0;
            for (i = 0; i < CFG_N; i = i + 1)
            begin
                cfg_mem[i] <= CFG_DEFAULT[i*8 +: 8];
                soc_mem[i] <= 8'h00;
            end
        end
        else
        begin
            spi_start_r     <= 1'b0;
            hub_cfg_wr_r    <= 1'b0;
            chg_det_start_r <= 1'b0;
            otp_smb_gnt_r   <= 1'b0;
            otp_usb_gnt_r   <= 1'b0;
            case (stage_r)
                ST_STBY:
                begin
                    stage_r     <= ST_SPI;
                    ports_hiz_r <= 1'b0;
                    pll_run_r   <= 1'b1;
                end
                ST_SPI:
                begin
                    if (!spi_en_s)
                        stage_r <= ST_CFGRD;
                    else if (lock_s && !spi_busy_r)
                    begin
                        spi_start_r <= 1'b1;
                        spi_busy_r  <= 1'b1;
                    end
                    else if (spi_done)
                    begin
                        spi_busy_r <= 1'b0;
                        if (spi_sig_ok)
                        begin
                            stage_r          <= ST_EXT;
                            ext_rom_en_r     <= 1'b1;
                            ext_fetch_addr_r <= `HBS_CODE_START;
                        end
                        else
                            stage_r <= ST_CFGRD;
                    end
                end
                ST_EXT:
                    stage_r <= ST_EXT;
                ST_CFGRD:
                begin
                    for (i = 0; i < CFG_N; i = i + 1)
                        cfg_mem[i] <= CFG_DEFAULT[i*8 +: 8];
                    cfg_mem[`HBS_STRAP_IDX][`HBS_BC_LSB +: `HBS_BC_W] <= bc_s;
                    cfg_mem[`HBS_STRAP_IDX][`HBS_NONREM_LSB +: `HBS_NONREM_W] <=
                        nonrem_s;
                    stage_r <= ST_STRAP;
                end
                ST_STRAP:
                begin
                    slave_lat_r <= slave_s;
                    if (slave_s && sda_s && scl_s)
                    begin
                        stage_r        <= ST_SOC;
                        smb_slave_en_r <= 1'b1;
                    end
                    else
                        stage_r <= ST_OTP;
                end
                ST_SOC:
                begin
                    otp_smb_gnt_r <= otp_smb_req;
                    if (end_wr_w)
                    begin
                        stage_r        <= ST_OTP;
                        smb_slave_en_r <= slave_lat_r;
                    end
                    else if (cfg_wr_stb && (cfg_wr_addr < CFG_N))
                    begin
                        soc_mem[cfg_wr_addr[IW-1:0]]   <= cfg_wr_data;
                        soc_vld_r[cfg_wr_addr[IW-1:0]] <= 1'b1;
                    end
                end
                ST_OTP:
                begin
                    hub_cfg_wr_r   <= 1'b1;
                    hub_cfg_addr_r <= {{(8-IW){1'b0}}, mi_r};
                    hub_cfg_data_r <= merged_w;
                    if (mi_r == `HBS_STRAP_IDX)
                        bc_en_r <= |merged_w[`HBS_BC_LSB +: `HBS_BC_W];
                    if (mi_r == CFG_N - 1)
                        stage_r <= ST_IDLE;
                    else
                        mi_r <= mi_r + {{(IW-1){1'b0}}, 1'b1};
                end
                ST_IDLE:
                begin
                    suspend_r <= ~vbus_s;
                    if (vbus_s)
                    begin
                        suspend_r <= 1'b0;
                        if (bc_en_r)
                        begin
                            stage_r         <= ST_CHG;
                            chg_det_start_r <= 1'b1;
                        end
                        else
                            stage_r <= ST_CONN;
                    end
                end
                ST_CHG:
                    if (chg_det_done)
                        stage_r <= ST_CONN;
                ST_CONN:
                begin
                    usb_connect_r <= vbus_s;
                    if (!vbus_s)
                        stage_r <= ST_IDLE;
                    else if (host_configured)
                        stage_r <= ST_NORM;
                end
                ST_NORM:
                begin
                    usb_connect_r <= vbus_s;
                    otp_usb_gnt_r <= otp_usb_req;
                    if (bc_ovr_stb)
                        bc_en_r <= bc_ovr_val;
                end
                default:
                    stage_r <= ST_STBY;
            endcase
        end
    end
endmodule // hbs_boot_seq

// [testbench/hbs_boot_seq_monitor.sv]
// assertion checker for the boot stage sequencer
`timescale 1ns/1ps
module hbs_boot_seq_monitor (
    input wire        ref_clk,          // clock
    input wire        rst,              // reset
    input wire        chip_reset_n_pin, // reset pin
    input wire        cfg_wr_stb,       // soc write
    input wire [7:0]  cfg_wr_addr,      // soc address
    input wire        otp_smb_req,      // otp request
    input wire [10:0] stage_r,          // stage
    input wire        ports_hiz_r,      // ports high-z
    input wire        pll_run_r,        // pll on
    input wire        ext_rom_en_r,     // ext rom on
    input wire [15:0] ext_fetch_addr_r, // fetch start
    input wire        otp_smb_gnt_r,    // otp grant
    input wire        hub_cfg_wr_r,     // merge write
    input wire [7:0]  hub_cfg_addr_r,   // merge index
    input wire        suspend_r         // suspended
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_standby_outputs: assert property (stage_r == 11'h001 |-> ports_hiz_r && !pll_run_r)
        else $error("standby outputs wrong");
    a_spi_init_pll: assert property (stage_r == 11'h002 |-> pll_run_r && !ports_hiz_r)
        else $error("spi init outputs wrong");
    a_ext_fetch_zero: assert property ($rose(stage_r[2]) |->
        ##[0:1] (ext_rom_en_r && ext_fetch_addr_r == 16'h0000)) else $error("ext rom start wrong");
    a_soc_end_write: assert property (chip_reset_n_pin[*5] ##0 (stage_r == 11'h020
        && cfg_wr_stb && cfg_wr_addr == 8'hFF) |=> stage_r == 11'h040)
        else $error("soc end ignored");
    a_soc_wait: assert property (chip_reset_n_pin[*5] ##0 (stage_r == 11'h020 &&
        !(cfg_wr_stb && cfg_wr_addr == 8'hFF)) |=> stage_r == 11'h020) else $error("soc left");
    a_merge_order: assert property ($rose(stage_r[6]) |-> ##[0:1] (hub_cfg_wr_r &&
        hub_cfg_addr_r == 8'h00) ##7 (hub_cfg_wr_r && hub_cfg_addr_r == 8'h07))
        else $error("merge order wrong");
    a_suspend_idle: assert property (suspend_r |-> stage_r[7] || $past(stage_r[7]))
        else $error("suspend outside idle");
    a_otp_smb_grant: assert property (otp_smb_gnt_r |-> $past(otp_smb_req) && $past(stage_r[5]))
        else $error("otp grant wrong");
endmodule // hbs_boot_seq_monitor
bind hbs_boot_seq hbs_boot_seq_monitor u_mon (.*);

// [testbench/hbs_flash_model.sv]
// flash holding the upgrade signature, single or dual read
`timescale 1ns/1ps
`include "hbs_regs.vh"
module hbs_flash_model (
    input  wire sck,  // flash clock
    input  wire cs_n, // select, low active
    input  wire dual, // dual output read
    input  wire bad,  // corrupt signature
    output reg  io0,  // data on io0
    output reg  io1   // data on io1
);
    reg [6:0]  n = 7'h00;
    reg [31:0] w;
    initial {io0, io1} = 2'b01;
    always @(negedge cs_n) n = 7'h00;
    always @(posedge sck) if (!cs_n) n = n + 7'h01;
    // data moves on falling sck, read on rising
    always @(negedge sck) if (!cs_n)
    begin
        w = `HBS_SIG_WORD ^ {31'h0, bad};
        if (!dual && n >= 7'h20 && n < 7'h40) io1 = w[7'h3F - n];
        if (dual && n >= 7'h28 && n < 7'h38) {io1, io0} = w[31 - 2 * (n - 40) -: 2];
    end
    // released lines do not keep the last bit
    always @(posedge cs_n) {io0, io1} = ~{io0, io1};
endmodule // hbs_flash_model

// [testbench/hbs_boot_seq_test.sv]
// self-checking bench for the boot stage sequencer
`timescale 1ns/1ps
module hbs_boot_seq_test;
    reg ref_clk = 0, rst = 1, chip_reset_n_pin = 0, pll_lock_pin = 0, vbus_pin = 0;
    reg mgmt_bus_data_pin = 0, mgmt_bus_clock_pin = 0, strap_spi_en = 0, strap_spi_dual = 0;
    reg strap_spi_mode3 = 0, slave_setup_option = 0, bad_sig = 0, cfg_wr_stb = 0;
    reg [2:0] strap_bc_en = 0, strap_non_rem = 0;
    reg [7:0] cfg_wr_addr = 0, cfg_wr_data = 0, otp_cfg_vld = 0, d0, d3;
    reg [63:0] otp_cfg_data = 0;
    reg chg_det_done = 0, host_configured = 0, otp_smb_req = 0, otp_usb_req = 0;
    reg bc_ovr_stb = 0, bc_ovr_val = 0;
    wire spi_sck, spi_cs_n, spi_io0_o, spi_io0_oe, spi_io1_i, fl_io0, spi_io0_i;
    wire ports_hiz_r, pll_run_r, ext_rom_en_r, smb_slave_en_r, otp_smb_gnt_r, otp_usb_gnt_r;
    wire hub_cfg_wr_r, bc_en_r, suspend_r, chg_det_start_r, usb_connect_r;
    wire [10:0] stage_r;
    wire [15:0] ext_fetch_addr_r;
    wire [7:0]  hub_cfg_addr_r, hub_cfg_data_r;
    reg [10:0]  last_stage, exp_stage[$];
    reg [15:0]  exp_cfg[$];
    integer     fails = 0, n_compared = 0, cycles = 0;
    assign spi_io0_i = spi_io0_oe ? spi_io0_o : fl_io0;
    hbs_boot_seq #(.SPI_DIV(1)) dut (.*);
    hbs_flash_model u_flash (.sck(spi_sck), .cs_n(spi_cs_n), .dual(strap_spi_dual),
        .bad(bad_sig), .io0(fl_io0), .io1(spi_io1_i));
    always #10 ref_clk = ~ref_clk;
    task report_and_stop;
    begin
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
    endtask
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 8000)
        begin
            fails = fails + 1;
            report_and_stop;
        end
    end
    task chk(input [19:0] e, input [19:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    end
    endtask
    // ===========================================
    // result watcher
    always @(negedge ref_clk)
    begin
        if (stage_r !== last_stage)
        begin
            last_stage = stage_r;
            chk(exp_stage.size() ? exp_stage.pop_front() : 11'h7FF, stage_r);
        end
        if (hub_cfg_wr_r === 1'b1)
            chk(exp_cfg.size() ? exp_cfg.pop_front() : 20'hFFFFF, {hub_cfg_addr_r, hub_cfg_data_r});
    end
    // ===========================================
    // drivers
    task wait_for(input [10:0] s);
        integer i;
    begin
        for (i = 0; i < 2000 && stage_r !== s; i = i + 1) @(negedge ref_clk);
    end
    endtask
    task drop;
    begin
        chip_reset_n_pin = 0;
        exp_stage.push_back(11'h001);
        wait_for(11'h001);
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        {cfg_wr_stb, cfg_wr_addr, cfg_wr_data} = {1'b1, a, d};
        @(negedge ref_clk) cfg_wr_stb = 0;
        @(negedge ref_clk);
    end
    endtask
    task exp_merge(input [63:0] sd, input [7:0] sv, input [7:0] e0);
        integer i;
    begin
        for (i = 0; i < 8; i = i + 1)
            exp_cfg.push_back({i[7:0], sv[i] ? sd[8*i+:8] : otp_cfg_vld[i] ?
                otp_cfg_data[8*i+:8] : (i == 0 ? e0 : 8'h00)});
    end
    endtask
    initial
    begin
        void'($urandom(35983));
        exp_stage.push_back(11'h001);
        repeat (16) @(negedge ref_clk);
        rst = 0;
        chk(2'b10, {ports_hiz_r, pll_run_r});
        {strap_spi_en, pll_lock_pin} = 2'b11;
        exp_stage = {exp_stage, 11'h002, 11'h004};
        chip_reset_n_pin = 1;
        wait_for(11'h004);
        chk(17'h10000, {ext_rom_en_r, ext_fetch_addr_r});
        drop;
        chk(2'b10, {ports_hiz_r, ext_rom_en_r});
        {strap_spi_dual, strap_spi_mode3} = 2'b11;
        exp_stage = {exp_stage, 11'h002, 11'h004};
        chip_reset_n_pin = 1;
        wait_for(11'h004);
        chk(1, ext_rom_en_r);
        drop;
        {bad_sig, slave_setup_option, mgmt_bus_data_pin} = 3'h7;
        strap_bc_en = 3'h1 + $urandom % 7;
        strap_non_rem = $urandom;
        otp_cfg_data = {$urandom, $urandom};
        otp_cfg_vld = $urandom & 8'hFE;
        exp_stage = {exp_stage, 11'h002, 11'h008, 11'h010, 11'h040, 11'h080, 11'h100, 11'h200};
        exp_stage = {exp_stage, 11'h400};
        exp_merge(64'h0, 8'h00, {2'b00, strap_non_rem, strap_bc_en});
        chip_reset_n_pin = 1;
        wait_for(11'h080);
        repeat (4) @(negedge ref_clk);
        chk(1, suspend_r);
        vbus_pin = 1;
        wait_for(11'h100);
        chk(1, chg_det_start_r);
        chg_det_done = 1;
        wait_for(11'h200);
        repeat (3) @(negedge ref_clk);
        chk(1, usb_connect_r);
        {host_configured, otp_usb_req} = 2'b11;
        wait_for(11'h400);
        repeat (2) @(negedge ref_clk);
        chk(2'b11, {bc_en_r, otp_usb_gnt_r});
        {bc_ovr_stb, bc_ovr_val} = 2'b10;
        @(negedge ref_clk) bc_ovr_stb = 0;
        @(negedge ref_clk) chk(0, bc_en_r);
        {vbus_pin, chg_det_done, host_configured, otp_usb_req} = 0;
        drop;
        {strap_spi_en, mgmt_bus_clock_pin, bad_sig} = 3'b010;
        otp_cfg_data = {$urandom, $urandom};
        otp_cfg_vld = $urandom & 8'hFE;
        exp_stage = {exp_stage, 11'h002, 11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h200};
        exp_stage.push_back(11'h080);
        chip_reset_n_pin = 1;
        wait_for(11'h020);
        chk(1, smb_slave_en_r);
        otp_smb_req = 1;
        d0 = $urandom & 8'hF8;
        d3 = $urandom;
        wr(8'h00, d0);
        wr(8'h09, $urandom);
        wr(8'h03, d3);
        chk(1, otp_smb_gnt_r);
        repeat (20) @(negedge ref_clk);
        chk(11'h020, stage_r);
        exp_merge({32'h0, d3, 16'h0, d0}, 8'h09, 8'h00);
        wr(8'hFF, $urandom);
        otp_smb_req = 0;
        wait_for(11'h080);
        vbus_pin = 1;
        wait_for(11'h200);
        vbus_pin = 0;
        wait_for(11'h080);
        drop;
        @(negedge ref_clk) chk(0, exp_stage.size() + exp_cfg.size());
        report_and_stop;
    end
endmodule // hbs_boot_seq_test
